// ===== rtl/acd_clock_divider.v
// Clock configuration block: source select, internal clock divider, modulator
// clock divider and data rate strobe, with the two clock configuration registers.
// Assumes a single 125 MHz system clock; the crystal and serial clock pins are
// asynchronous and much slower than it; software uses the plain register port.
//
// Overview of operation
// - Bit 7 selects crystal or serial clock
// - Bits 3:1 divide source by even ratio
// - Synchronous master drives internal clock out unless bit 7 picks serial clock
// - Register one at 0Dh, reset 08h, reserved zero
// - Register two at 0Eh, reset 86h
// - Modulator divider top, bit 4 zero, ratio low
// - Ratio code sets output data rate
`timescale 1ns/1ps
`include "acd_clk_map.vh"

module acd_clock_divider (
  input wire clock,
  input wire rst_n,
  input wire [7:0] regAddr,
  input wire [7:0] regWrData,
  input wire regWrStrobe,
  input wire regRdStrobe,
  output reg [7:0] regRdData,
  input wire crystalClockPin,
  input wire serialClockIn,
  output reg serialClockOut,
  output reg serialClockOe,
  output wire internalClock,
  output wire modulatorClock,
  output reg dataReadyPulse
);

////////////////////////////////////////////////////////////////////////////////
// Functions

// Half period in source edges; the reserved code 0 behaves as code 1
function [`ACD_HALF_W-1:0] halfOf;
  input [`ACD_HALF_W-1:0] code;
  begin
    halfOf = (code == {`ACD_HALF_W{1'b0}}) ? {{(`ACD_HALF_W-1){1'b0}}, 1'b1} : code;
  end
endfunction

// Decimation ratio from the four-bit code
function [`ACD_RATIO_W-1:0] ratioOf;
  input [3:0] code;
  begin
    case (code)
      4'h0: ratioOf = 13'd4096;
      4'h1: ratioOf = 13'd2048;
      4'h2: ratioOf = 13'd1024;
      4'h3: ratioOf = 13'd800;
      4'h4: ratioOf = 13'd768;
      4'h5: ratioOf = 13'd512;
      4'h6: ratioOf = 13'd400;
      4'h7: ratioOf = 13'd384;
      4'h8: ratioOf = 13'd256;
      4'h9: ratioOf = 13'd200;
      4'hA: ratioOf = 13'd192;
      4'hB: ratioOf = 13'd128;
      4'hC: ratioOf = 13'd96;
      4'hD: ratioOf = 13'd64;
      4'hE: ratioOf = 13'd48;
      default: ratioOf = 13'd32;
    endcase
  end
endfunction

// Synchroniser stage two and three agree
function settled;
  input a;
  input b;
  begin
    settled = (a == b);
  end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Registers

reg [7:0] clkOne_q;
reg [7:0] clkTwo_q;
reg [7:0] linkMode_q;
reg srcSel_q;
reg iclkRestart_q;
reg modRestart_q;

wire wrClkOne;
wire wrClkTwo;
wire wrLinkMode;
wire masterMode;

assign wrClkOne = regWrStrobe && (regAddr == `ACD_ADDR_CLK_ONE);
assign wrClkTwo = regWrStrobe && (regAddr == `ACD_ADDR_CLK_TWO);
assign wrLinkMode = regWrStrobe && (regAddr == `ACD_ADDR_LINK_MODE);
assign masterMode = linkMode_q[`ACD_MASTER_BIT];

always @(posedge clock) begin
  if (!rst_n) begin
    clkOne_q <= `ACD_RST_CLK_ONE;
    clkTwo_q <= `ACD_RST_CLK_TWO;
    linkMode_q <= `ACD_RST_LINK_MODE;
  end else begin
    if (wrClkOne) begin
      clkOne_q <= regWrData & `ACD_MASK_CLK_ONE;
    end
    if (wrClkTwo) begin
      clkTwo_q <= regWrData & `ACD_MASK_CLK_TWO;
    end
    if (wrLinkMode) begin
      linkMode_q <= regWrData & `ACD_MASK_LINK_MODE;
    end
  end
end

// Any rewrite of a divider field restarts the affected counters
always @(posedge clock) begin
  if (!rst_n) begin
    iclkRestart_q <= 1'b0;
    modRestart_q <= 1'b0;
  end else begin
    iclkRestart_q <= wrClkOne;
    modRestart_q <= wrClkOne || wrClkTwo;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Read port: data stands only in the cycle after the strobe

always @(posedge clock) begin
  if (!rst_n) begin
    regRdData <= 8'h00;
  end else if (regRdStrobe) begin
    case (regAddr)
      `ACD_ADDR_CLK_ONE: regRdData <= clkOne_q;
      `ACD_ADDR_CLK_TWO: regRdData <= clkTwo_q;
      `ACD_ADDR_LINK_MODE: regRdData <= linkMode_q;
      `ACD_ADDR_STATUS: regRdData <= {4'h0, serialClockOe, srcSel_q, modulatorClock,
                                      internalClock};
      default: regRdData <= 8'h00;
    endcase
  end else begin
    regRdData <= 8'h00;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Pin synchronisers

reg xtalS1_q;
reg xtalS2_q;
reg xtalS3_q;
reg xtalLvl_q;
reg sclkS1_q;
reg sclkS2_q;
reg sclkS3_q;
reg sclkLvl_q;

always @(posedge clock) begin
  if (!rst_n) begin
    xtalS1_q <= 1'b0;
    xtalS2_q <= 1'b0;
    xtalS3_q <= 1'b0;
    xtalLvl_q <= 1'b0;
    sclkS1_q <= 1'b0;
    sclkS2_q <= 1'b0;
    sclkS3_q <= 1'b0;
    sclkLvl_q <= 1'b0;
  end else begin
    xtalS1_q <= crystalClockPin;
    xtalS2_q <= xtalS1_q;
    xtalS3_q <= xtalS2_q;
    if (settled(xtalS2_q, xtalS3_q)) begin
      xtalLvl_q <= xtalS3_q;
    end
    sclkS1_q <= serialClockIn;
    sclkS2_q <= sclkS1_q;
    sclkS3_q <= sclkS2_q;
    if (settled(sclkS2_q, sclkS3_q)) begin
      sclkLvl_q <= sclkS3_q;
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// Source selection and edge detection

reg srcLvl_q;
reg srcTick_q;
wire srcLvl_d;

assign srcLvl_d = clkOne_q[`ACD_SRC_BIT] ? sclkLvl_q : xtalLvl_q;

always @(posedge clock) begin
  if (!rst_n) begin
    srcSel_q <= 1'b0;
    srcLvl_q <= 1'b0;
    srcTick_q <= 1'b0;
  end else begin
    srcSel_q <= clkOne_q[`ACD_SRC_BIT];
    if (srcSel_q != clkOne_q[`ACD_SRC_BIT]) begin
      // Swallow the spurious edge a source swap could fake
      srcLvl_q <= srcLvl_d;
      srcTick_q <= 1'b0;
    end else begin
      srcLvl_q <= srcLvl_d;
      srcTick_q <= srcLvl_d && !srcLvl_q;
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// Internal clock divider

wire iclkRise;

acd_edge_divider iclkDiv (
  .clock(clock),
  .rst_n(rst_n),
  .srcTick(srcTick_q),
  .halfCount(halfOf(clkOne_q[`ACD_DIV_MSB:`ACD_DIV_LSB])),
  .restart(iclkRestart_q),
  .clkOut(internalClock),
  .risePulse(iclkRise)
);

////////////////////////////////////////////////////////////////////////////////
// Serial clock output in synchronous master mode

always @(posedge clock) begin
  if (!rst_n) begin
    serialClockOut <= 1'b0;
    serialClockOe <= 1'b0;
  end else begin
    // No drive while the serial pin itself is the clock source
    serialClockOe <= masterMode && !clkOne_q[`ACD_SRC_BIT];
    serialClockOut <= internalClock;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Modulator clock divider

wire modRise;

acd_edge_divider modDiv (
  .clock(clock),
  .rst_n(rst_n),
  .srcTick(iclkRise),
  .halfCount(halfOf(clkTwo_q[`ACD_MDIV_MSB:`ACD_MDIV_LSB])),
  .restart(modRestart_q),
  .clkOut(modulatorClock),
  .risePulse(modRise)
);

////////////////////////////////////////////////////////////////////////////////
// Output data rate strobe

reg [`ACD_RATIO_W-1:0] decCnt_q;
wire [`ACD_RATIO_W-1:0] ratio;

assign ratio = ratioOf(clkTwo_q[`ACD_OSR_MSB:`ACD_OSR_LSB]);

always @(posedge clock) begin
  if (!rst_n) begin
    decCnt_q <= {`ACD_RATIO_W{1'b0}};
    dataReadyPulse <= 1'b0;
  end else begin
    dataReadyPulse <= 1'b0;
    if (modRestart_q) begin
      decCnt_q <= {`ACD_RATIO_W{1'b0}};
    end else if (modRise) begin
      if (decCnt_q >= ratio - 1'b1) begin
        decCnt_q <= {`ACD_RATIO_W{1'b0}};
        dataReadyPulse <= 1'b1;
      end else begin
        decCnt_q <= decCnt_q + 1'b1;
      end
    end
  end
end

endmodule // acd_clock_divider

// ===== rtl/acd_clk_map.vh
// Register map, field positions and reset values of the clock configuration block.
// Assumes an 8-bit register address and 8-bit register data.
`ifndef ACD_CLK_MAP_VH
`define ACD_CLK_MAP_VH

// Register addresses
`define ACD_ADDR_CLK_ONE 8'h0D
`define ACD_ADDR_CLK_TWO 8'h0E
`define ACD_ADDR_LINK_MODE 8'h10
`define ACD_ADDR_STATUS 8'h11

// Reset values
`define ACD_RST_CLK_ONE 8'h08
`define ACD_RST_CLK_TWO 8'h86
`define ACD_RST_LINK_MODE 8'h00

// Writable bit masks; reserved bits are held at zero
`define ACD_MASK_CLK_ONE 8'h8E
`define ACD_MASK_CLK_TWO 8'hEF
`define ACD_MASK_LINK_MODE 8'h01

// clock_config_one fields
`define ACD_SRC_BIT 7
`define ACD_DIV_MSB 3
`define ACD_DIV_LSB 1

// clock_config_two fields
`define ACD_MDIV_MSB 7
`define ACD_MDIV_LSB 5
`define ACD_OSR_MSB 3
`define ACD_OSR_LSB 0

// Link mode field
`define ACD_MASTER_BIT 0

// Widths
`define ACD_HALF_W 3
`define ACD_RATIO_W 13

`endif

// ===== rtl/acd_edge_divider.v
// Even-ratio divider driven by rising-edge ticks of a sampled source clock.
// Assumes srcTick is a one-cycle pulse on the system clock, one per source rising edge.
`timescale 1ns/1ps
`include "acd_clk_map.vh"

module acd_edge_divider (
  input wire clock,
  input wire rst_n,
  input wire srcTick,
  input wire [`ACD_HALF_W-1:0] halfCount,
  input wire restart,
  output reg clkOut,
  output reg risePulse
);

reg [`ACD_HALF_W-1:0] cnt_q;
reg pend_q;

////////////////////////////////////////////////////////////////////////////////
// Counter and output toggle
always @(posedge clock) begin
  if (!rst_n) begin
    cnt_q <= {`ACD_HALF_W{1'b0}};
    pend_q <= 1'b0;
    clkOut <= 1'b0;
    risePulse <= 1'b0;
  end else begin
    risePulse <= 1'b0;
    if (pend_q && !clkOut) begin
      // Restart only in the low phase so no high pulse is cut short
      cnt_q <= {`ACD_HALF_W{1'b0}};
      pend_q <= restart;
    end else begin
      if (restart) begin
        pend_q <= 1'b1;
      end
      if (srcTick) begin
        if (cnt_q + 1'b1 >= halfCount) begin
          cnt_q <= {`ACD_HALF_W{1'b0}};
          clkOut <= ~clkOut;
          risePulse <= ~clkOut;
        end else begin
          cnt_q <= cnt_q + 1'b1;
        end
      end
    end
  end
end

endmodule // acd_edge_divider

// ===== dv/acd_clk_source.sv
// Clock sources facing the block: crystal pin and host serial clock.
// Assumes the bench lets the host clock run only while it asks for it.
`timescale 1ns/1ps
module acd_clk_source #(
  parameter int XHALF = 28,
  parameter int SHALF = 44
) (
  output logic xtalPin,
  output logic hostClk,
  input wire logic hostRun
);
  initial begin
    xtalPin = 1'b0;
    forever #(XHALF) xtalPin = ~xtalPin;
  end
  // Host clock stands low outside its bursts
  initial begin
    hostClk = 1'b0;
    forever begin
      #(SHALF);
      hostClk = hostRun ? ~hostClk : 1'b0;
    end
  end
endmodule // acd_clk_source

// ===== dv/acd_clk_sva.sv
// Checker of the clock configuration block.
// Assumes it sees only the ports of the top module.
`timescale 1ns/1ps
module acd_clk_sva (
  input wire clock,
  input wire rst_n,
  input wire [7:0] regAddr,
  input wire [7:0] regWrData,
  input wire regWrStrobe,
  input wire regRdStrobe,
  input wire [7:0] regRdData,
  input wire serialClockOut,
  input wire serialClockOe,
  input wire internalClock,
  input wire modulatorClock,
  input wire dataReadyPulse
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////
  AST_RD_ONE: assert property (regRdStrobe && regAddr == 8'h0D |=> (regRdData & 8'h71) == 8'h00)
    else $error("reserved bits one");
  AST_RD_TWO: assert property (regRdStrobe && regAddr == 8'h0E |=> !regRdData[4])
    else $error("reserved bit two");
  AST_WR_ONE: assert property (regWrStrobe && regAddr == 8'h0D ##1 regRdStrobe && regAddr == 8'h0D
    |=> regRdData == ($past(regWrData, 2) & 8'h8E))
    else $error("register one readback");
  AST_WR_TWO: assert property (regWrStrobe && regAddr == 8'h0E ##1 regRdStrobe && regAddr == 8'h0E
    |=> regRdData == ($past(regWrData, 2) & 8'hEF))
    else $error("register two readback");
  AST_SCK_OUT: assert property (serialClockOe |-> serialClockOut == $past(internalClock))
    else $error("serial clock out");
  AST_DRDY_ONE: assert property (dataReadyPulse |=> !dataReadyPulse)
    else $error("data ready too long");
  AST_DRDY_MOD: assert property (dataReadyPulse |-> $past(modulatorClock) && !$past(modulatorClock, 2))
    else $error("data ready off modulator rise");
  AST_INTERNAL_CLOCK_HOLD: assert property ($rose(internalClock) |=> internalClock[*5])
    else $error("internal clock runt");
  AST_MOD_HOLD: assert property ($rose(modulatorClock) |=> modulatorClock[*8])
    else $error("modulator clock runt");
  cover property (dataReadyPulse);
  cover property (serialClockOe && $rose(serialClockOut));
  cover property (regWrStrobe && regAddr == 8'h0E);
endmodule // acd_clk_sva

bind acd_clock_divider acd_clk_sva u_sva (.clock(clock), .rst_n(rst_n), .regAddr(regAddr),
  .regWrData(regWrData), .regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe),
  .regRdData(regRdData), .serialClockOut(serialClockOut), .serialClockOe(serialClockOe),
  .internalClock(internalClock), .modulatorClock(modulatorClock),
  .dataReadyPulse(dataReadyPulse));

// ===== dv/tb.sv
// Self-checking bench of the clock configuration block.
// Assumes the clock source model and the checker are compiled first.
`timescale 1ns/1ps
module tb;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWrData = 8'h00;
  logic regWrStrobe = 1'b0;
  logic regRdStrobe = 1'b0;
  logic hostRun = 1'b0;
  wire [7:0] regRdData;
  wire xtalPin, hostClk, serialClockOut, serialClockOe, internalClock, modulatorClock, dataReadyPulse;
  wire serialClockIn = serialClockOe ? serialClockOut : hostClk;
  int error_cnt = 0;
  int n_compared = 0;
  int osrTab [8] = '{256, 200, 192, 128, 96, 64, 48, 32};
  time t0;
  initial forever #4 clock = ~clock;
  acd_clk_source src (.xtalPin(xtalPin), .hostClk(hostClk), .hostRun(hostRun));
  acd_clock_divider dut (.clock(clock), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe), .regRdData(regRdData),
    .crystalClockPin(xtalPin), .serialClockIn(serialClockIn), .serialClockOut(serialClockOut),
    .serialClockOe(serialClockOe), .internalClock(internalClock),
    .modulatorClock(modulatorClock), .dataReadyPulse(dataReadyPulse));
  ////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    regWrStrobe <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clock);
    regWrStrobe <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    regRdStrobe <= 1'b1;
    regAddr <= a;
    @(posedge clock);
    regRdStrobe <= 1'b0;
    #1 chk("read data", {24'h0, exp}, {24'h0, regRdData});
  endtask
  // Write then read back with no gap between the two strobes
  task automatic wrrd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] exp);
    @(posedge clock);
    regWrStrobe <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clock);
    regWrStrobe <= 1'b0;
    regRdStrobe <= 1'b1;
    @(posedge clock);
    regRdStrobe <= 1'b0;
    #1 chk("readback", {24'h0, exp}, {24'h0, regRdData});
  endtask
  task automatic edge_of(input int which);
    case (which)
      0: @(posedge internalClock);
      1: @(posedge serialClockOut);
      3: @(posedge modulatorClock);
      default: @(posedge dataReadyPulse);
    endcase
  endtask
  // Period between two rises, allowing for pin synchroniser jitter
  task automatic gap(input int which, input int expNs);
    time d;
    edge_of(which);
    t0 = $time;
    edge_of(which);
    d = $time - t0;
    if (d > expNs - 16 && d < expNs + 16) d = expNs;
    chk("period ns", 32'(expNs), 32'(d));
  endtask
  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge clock);
    error_cnt++;
    test_done();
  end
  initial begin
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    rd(8'h11, 8'h00);
    rd(8'h0D, 8'h08);
    rd(8'h0E, 8'h86);
    gap(3, 3584);
    wrrd(8'h0D, 8'hFF, 8'h8E);
    wrrd(8'h0E, 8'hFF, 8'hEF);
    rd(8'h20, 8'h00);
    for (int c = 0; c < 8; c++) begin
      wr(8'h0D, 8'(c << 1));
      gap(0, 112 * (c == 0 ? 1 : c));
    end
    hostRun <= 1'b1;
    wr(8'h0D, 8'h82);
    gap(0, 176);
    wr(8'h10, 8'h01);
    repeat (4) @(posedge clock);
    #1 chk("drive enable", 0, {31'h0, serialClockOe});
    wr(8'h10, 8'h00);
    hostRun <= 1'b0;
    wr(8'h0D, 8'h02);
    wr(8'h10, 8'h01);
    repeat (4) @(posedge clock);
    #1 chk("drive enable", 1, {31'h0, serialClockOe});
    gap(1, 112);
    wr(8'h10, 8'h00);
    for (int c = 8; c < 16; c++) begin
      wr(8'h0E, 8'h20 | 8'(c));
      gap(2, osrTab[c - 8] * 224);
    end
    test_done();
  end
endmodule // tb
